// [verilog/dpcs_pkg.sv]
package dpcs_pkg;
  // Host register indices
  localparam logic [3:0] ADDR_TARGET = 4'h6;
  localparam logic [3:0] ADDR_REF_FLAGS = 4'hf;
  localparam int TARGET_FLAG_BIT = 1;
  localparam logic [15:0] TARGET_RESET = 16'h0000;
  localparam logic [15:0] REF_FLAGS_RESET = 16'h0000;
  // Contact input function codes
  localparam logic [7:0] FN_PID_DISABLE = 8'h13;
  localparam logic [7:0] FN_INT_RESET = 8'h1e;
  localparam logic [7:0] FN_INT_HOLD = 8'h1f;
  localparam logic [7:0] FN_SOFT_START = 8'h22;
  localparam logic [7:0] FN_CHAR_SWITCH = 8'h23;
  // Analog function codes
  localparam logic [4:0] AN_FEEDBACK = 5'h0b;
  localparam logic [4:0] AN_TARGET = 5'h0c;
  // Pulse input function
  localparam logic [1:0] PULSE_FREQ = 2'h0;
  localparam logic [1:0] PULSE_FEEDBACK = 2'h1;
  localparam logic [1:0] PULSE_TARGET = 2'h2;
  // Method selection
  localparam logic [2:0] METHOD_OFF = 3'h0;
  // Control step period, in microseconds, and its length in clock cycles
  localparam int CLK_MHZ = 50;
  localparam int STEP_US = 1000;
  localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
  // Fractional bits of gain settings (Q8.8)
  localparam int GAIN_FRAC = 8;

  typedef struct packed {
    logic [2:0] method;
    logic [15:0] prop_gain;
    logic [15:0] integral_time;
    logic [15:0] derivative_time;
    logic [15:0] filter_time;
    logic [15:0] ramp_time;
    logic [4:0] second_fn;
    logic [4:0] third_fn;
    logic [1:0] pulse_fn;
  } dpcs_cfg_t;

  typedef struct packed {
    logic [15:0] second_analog;
    logic [15:0] third_analog;
    logic [15:0] pulse;
    logic [15:0] freq_ref;
  } dpcs_src_t;

  typedef struct packed {
    logic [15:0] gain;
    logic [15:0] bias;
  } dpcs_adj_t;
endpackage : dpcs_pkg

// [verilog/dpcs_scale.sv]
// Gain (Q8.8) and bias, saturated to signed 16 bits
module dpcs_scale
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] raw,
  input wire dpcs_pkg::dpcs_adj_t adj,
  output logic [15:0] scaled
);
  logic signed [33:0] prod;
  logic signed [33:0] sum;

  always_comb
  begin
    prod = 34'(($signed(raw) * $signed(adj.gain)) >>> dpcs_pkg::GAIN_FRAC);
    sum = prod + 34'($signed(adj.bias));
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      scaled <= 16'h0000;
    else if (sum > 34'sd32767)
      scaled <= 16'h7fff;
    else if (sum < -34'sd32768)
      scaled <= 16'h8000;
    else
      scaled <= sum[15:0];
  end
endmodule : dpcs_scale

// [verilog/dpcs_top.sv]
module dpcs_top
#(
  parameter int NUM_CONTACTS = 10,
  parameter int STEP_CYCLES = dpcs_pkg::STEP_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire dpcs_pkg::dpcs_cfg_t cfg,
  input wire logic [NUM_CONTACTS*8-1:0] contact_fn,
  input wire logic [NUM_CONTACTS-1:0] contact_pin,
  input wire dpcs_pkg::dpcs_src_t src,
  input wire dpcs_pkg::dpcs_adj_t second_adj,
  input wire dpcs_pkg::dpcs_adj_t third_adj,
  input wire dpcs_pkg::dpcs_adj_t pulse_adj,
  input wire logic [15:0] pulse_scale,
  input wire logic [15:0] max_freq,
  input wire logic run,
  input wire logic reset_cmd,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [3:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_ack,
  output logic [15:0] freq_out,
  output logic [15:0] freq_ref_out,
  output logic pid_active,
  output logic char_switch,
  output logic [15:0] pid_out_mon
);
  logic [NUM_CONTACTS-1:0] pin_s1_reg;
  logic [NUM_CONTACTS-1:0] pin_s2_reg;
  logic [15:0] target_reg;
  logic [15:0] flags_reg;
  logic [15:0] second_v;
  logic [15:0] third_v;
  logic [15:0] pulse_v;
  logic [15:0] pulse_pre;
  logic [NUM_CONTACTS-1:0] hit_dis, hit_rst, hit_hold, hit_soft, hit_char;
  logic pid_disable, int_reset, int_hold, soft_start;
  logic signed [15:0] target_raw, feedback;
  logic signed [15:0] ramp_reg;
  logic [31:0] ramp_cnt_reg;
  logic [31:0] step_cnt_reg;
  logic step;
  logic signed [31:0] integ_reg;
  logic signed [15:0] prev_d_reg;
  logic signed [15:0] filt_reg;
  logic signed [31:0] err, d_in, p_term, d_term, pid_sum, pid_sat;
  logic signed [31:0] freq_sum;
  logic pid_on;

  // Contact inputs come from pins
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end
    else
    begin
      pin_s1_reg <= contact_pin;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  generate
    for (genvar i = 0; i < NUM_CONTACTS; i++)
    begin : g_contact
      logic [7:0] fn;
      assign fn = contact_fn[i*8 +: 8];
      assign hit_dis[i] = pin_s2_reg[i] && fn == dpcs_pkg::FN_PID_DISABLE;
      assign hit_rst[i] = pin_s2_reg[i] && fn == dpcs_pkg::FN_INT_RESET;
      assign hit_hold[i] = pin_s2_reg[i] && fn == dpcs_pkg::FN_INT_HOLD;
      assign hit_soft[i] = pin_s2_reg[i] && fn == dpcs_pkg::FN_SOFT_START;
      assign hit_char[i] = pin_s2_reg[i] && fn == dpcs_pkg::FN_CHAR_SWITCH;
    end
  endgenerate

  assign pid_disable = |hit_dis;
  assign int_reset = |hit_rst;
  assign int_hold = |hit_hold;
  assign soft_start = |hit_soft;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      char_switch <= 1'b0;
    else
      char_switch <= |hit_char;
  end

  // Host registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      target_reg <= dpcs_pkg::TARGET_RESET;
      flags_reg <= dpcs_pkg::REF_FLAGS_RESET;
    end
    else if (host_wr)
    begin
      if (host_addr == dpcs_pkg::ADDR_TARGET)
        target_reg <= host_wdata;
      if (host_addr == dpcs_pkg::ADDR_REF_FLAGS)
        flags_reg <= host_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      host_rdata <= 16'h0000;
      host_ack <= 1'b0;
    end
    else
    begin
      host_ack <= host_wr || host_rd;
      if (host_rd && host_addr == dpcs_pkg::ADDR_TARGET)
        host_rdata <= target_reg;
      else if (host_rd && host_addr == dpcs_pkg::ADDR_REF_FLAGS)
        host_rdata <= flags_reg;
      else if (host_rd)
        host_rdata <= 16'h0000;
    end
  end

  // Input conditioning
  dpcs_scale u_second (.clk(clk), .rst_b(rst_b), .raw(src.second_analog),
    .adj(second_adj), .scaled(second_v));
  dpcs_scale u_third (.clk(clk), .rst_b(rst_b), .raw(src.third_analog),
    .adj(third_adj), .scaled(third_v));
  assign pulse_pre = 16'((32'(src.pulse) * 32'(pulse_scale)) >> dpcs_pkg::GAIN_FRAC);
  dpcs_scale u_pulse (.clk(clk), .rst_b(rst_b), .raw(pulse_pre),
    .adj(pulse_adj), .scaled(pulse_v));

  // Source selection; all values in units of max frequency
  always_comb
  begin
    target_raw = $signed(src.freq_ref);
    if (cfg.pulse_fn == dpcs_pkg::PULSE_TARGET)
      target_raw = $signed(pulse_v);
    if (cfg.third_fn == dpcs_pkg::AN_TARGET)
      target_raw = $signed(third_v);
    if (cfg.second_fn == dpcs_pkg::AN_TARGET)
      target_raw = $signed(second_v);
    if (flags_reg[dpcs_pkg::TARGET_FLAG_BIT])
      target_raw = $signed(target_reg);
    feedback = 16'sh0000;
    if (cfg.pulse_fn == dpcs_pkg::PULSE_FEEDBACK)
      feedback = $signed(pulse_v);
    if (cfg.third_fn == dpcs_pkg::AN_FEEDBACK)
      feedback = $signed(third_v);
    if (cfg.second_fn == dpcs_pkg::AN_FEEDBACK)
      feedback = $signed(second_v);
  end

  // Pulse function 0 feeds freq_ref_out; freq_out still uses src.freq_ref
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      freq_ref_out <= 16'h0000;
    else if (cfg.pulse_fn == dpcs_pkg::PULSE_FREQ)
      freq_ref_out <= pulse_v;
    else
      freq_ref_out <= src.freq_ref;
  end

  // Control step tick
  always_ff @(posedge clk)
  begin
    if (!rst_b || step)
      step_cnt_reg <= '0;
    else
      step_cnt_reg <= step_cnt_reg + 32'd1;
  end
  assign step = step_cnt_reg == 32'(STEP_CYCLES - 1);

  assign pid_on = cfg.method != dpcs_pkg::METHOD_OFF && !pid_disable;

  // Target ramp: one count every ramp_time steps
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ramp_reg <= 16'sh0000;
      ramp_cnt_reg <= '0;
    end
    else if (soft_start || cfg.ramp_time == 16'h0000 || !pid_on)
    begin
      ramp_reg <= target_raw;
      ramp_cnt_reg <= '0;
    end
    else if (step)
    begin
      if (ramp_cnt_reg + 32'd1 >= 32'(cfg.ramp_time))
      begin
        ramp_cnt_reg <= '0;
        if (ramp_reg < target_raw)
          ramp_reg <= ramp_reg + 16'sd1;
        else if (ramp_reg > target_raw)
          ramp_reg <= ramp_reg - 16'sd1;
      end
      else
        ramp_cnt_reg <= ramp_cnt_reg + 32'd1;
    end
  end

  // PID terms
  always_comb
  begin
    err = 32'(ramp_reg) - 32'(feedback);
    d_in = (cfg.method == 3'h2 || cfg.method == 3'h4) ? -32'(feedback) : err;
    p_term = (err * $signed({16'h0000, cfg.prop_gain})) >>> dpcs_pkg::GAIN_FRAC;
    d_term = 32'sd0;
    if (cfg.derivative_time != 16'h0000)
      d_term = ((d_in - 32'(prev_d_reg)) * $signed({16'h0000, cfg.derivative_time}))
        >>> dpcs_pkg::GAIN_FRAC;
    pid_sum = p_term + integ_reg + d_term;
    if (pid_sum > 32'sd32767)
      pid_sat = 32'sd32767;
    else if (pid_sum < -32'sd32768)
      pid_sat = -32'sd32768;
    else
      pid_sat = pid_sum;
  end

  // Integrator: reset has priority over hold
  always_ff @(posedge clk)
  begin
    if (!rst_b || int_reset || reset_cmd || !run || !pid_on)
      integ_reg <= 32'sd0;
    else if (step && !int_hold && cfg.integral_time != 16'h0000)
      integ_reg <= integ_reg + err / $signed({16'h0000, cfg.integral_time});
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      prev_d_reg <= 16'sh0000;
    else if (step)
      prev_d_reg <= d_in[15:0];
  end

  // First-order output filter
  always_ff @(posedge clk)
  begin
    if (!rst_b || !pid_on)
      filt_reg <= 16'sh0000;
    else if (step)
    begin
      if (cfg.filter_time == 16'h0000)
        filt_reg <= pid_sat[15:0];
      else
        filt_reg <= 16'(32'(filt_reg) + (pid_sat - 32'(filt_reg))
          / $signed({16'h0000, cfg.filter_time} + 32'sd1));
    end
  end

  always_comb
  begin
    freq_sum = 32'($signed(src.freq_ref)) + 32'(filt_reg);
    if (freq_sum > 32'($signed(max_freq)))
      freq_sum = 32'($signed(max_freq));
    else if (freq_sum < -32'($signed(max_freq)))
      freq_sum = -32'($signed(max_freq));
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      freq_out <= 16'h0000;
      pid_active <= 1'b0;
      pid_out_mon <= 16'h0000;
    end
    else
    begin
      pid_active <= pid_on;
      pid_out_mon <= filt_reg;
      if (!pid_on)
        freq_out <= src.freq_ref;
      else if (cfg.method == 3'h1 || cfg.method == 3'h2)
        freq_out <= filt_reg;
      else
        freq_out <= freq_sum[15:0];
    end
  end
endmodule : dpcs_top

// [bench/dpcs_src_model.sv]
// Conditioned analog and pulse levels as the drive's front end settles them
module dpcs_src_model
(
  output wire dpcs_pkg::dpcs_src_t src
);
  timeunit 1ns;
  timeprecision 1ns;
  assign src.second_analog = 16'h0300;
  assign src.third_analog = 16'h0100;
  assign src.pulse = 16'h0080;
  assign src.freq_ref = 16'h0500;
endmodule : dpcs_src_model

// [bench/dpcs_top_sva.sv]
module dpcs_top_sva
(
  input wire logic clk,
  input wire logic rst_b,
  input wire dpcs_pkg::dpcs_cfg_t cfg,
  input wire dpcs_pkg::dpcs_src_t src,
  input wire logic [15:0] max_freq,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [3:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  input wire logic host_ack,
  input wire logic [15:0] freq_out,
  input wire logic pid_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  a_rd_ack_next: assert property (host_rd |=> host_ack)
    else $error("no ack after read");
  a_wr_ack_next: assert property (host_wr |=> host_ack)
    else $error("no ack after write");
  a_ack_no_strobe: assert property (!host_rd && !host_wr |=> !host_ack)
    else $error("ack without strobe");
  a_unmapped_read: assert property (host_rd && host_addr != 4'h6 && host_addr != 4'hf
    |=> host_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_target_readback: assert property (host_wr && host_addr == 4'h6 ##2
    host_rd && host_addr == 4'h6 |=> host_rdata == $past(host_wdata, 3))
    else $error("target readback wrong");
  a_rdata_holds: assert property (!host_rd |=> $stable(host_rdata))
    else $error("read data moved");
  a_method_off: assert property (cfg.method == 3'h0 && $stable(cfg.method)
    |=> freq_out == $past(src.freq_ref))
    else $error("reference not passed");
  a_off_inactive: assert property (cfg.method == 3'h0 |=> !pid_active)
    else $error("pid active while off");
  a_comp_clamp: assert property ((cfg.method inside {3'h3, 3'h4}) && $stable(cfg)
    |=> $signed(freq_out) <= $signed(max_freq))
    else $error("compensation above limit");
endmodule : dpcs_top_sva

bind dpcs_top dpcs_top_sva chk_u (.clk, .rst_b, .cfg, .src, .max_freq, .host_wr, .host_rd,
  .host_addr, .host_wdata, .host_rdata, .host_ack, .freq_out, .pid_active);

// [bench/dpcs_top_tb_top.sv]
module dpcs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [2:0] m;
    logic [15:0] g;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [1:0] pf;
    logic fl;
    logic [15:0] e;
  } dpcs_row_t;
  dpcs_row_t rows [8] = '{
    '{3'h0, 16'h0000, 5'h00, 5'h00, 2'h0, 1'b0, 16'h0500},
    '{3'h1, 16'h0100, 5'h00, 5'h00, 2'h0, 1'b1, 16'h0600},
    '{3'h1, 16'h0100, 5'h0c, 5'h00, 2'h1, 1'b0, 16'h0280},
    '{3'h2, 16'h0100, 5'h00, 5'h0b, 2'h0, 1'b0, 16'h0400},
    '{3'h1, 16'h0100, 5'h0b, 5'h00, 2'h2, 1'b0, 16'hfd80},
    '{3'h3, 16'h0000, 5'h00, 5'h00, 2'h0, 1'b0, 16'h0500},
    '{3'h4, 16'h0100, 5'h00, 5'h00, 2'h2, 1'b0, 16'h0580},
    '{3'h3, 16'h0100, 5'h00, 5'h00, 2'h0, 1'b1, 16'h0800}
  };
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  dpcs_pkg::dpcs_cfg_t cfg = '0;
  logic [9:0] pins = '0;
  dpcs_pkg::dpcs_src_t src;
  dpcs_pkg::dpcs_adj_t unity = '{16'h0100, 16'h0000};
  logic run = 1'b1;
  logic rcmd = 1'b0;
  logic hwr = 1'b0;
  logic hrd = 1'b0;
  logic [3:0] ha = '0;
  logic [15:0] hwd = '0;
  logic [15:0] hrdata, fout, fref, pmon, v;
  logic hack, pact, chs, hit;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  dpcs_src_model src_u (.src(src));
  dpcs_top #(.NUM_CONTACTS(10), .STEP_CYCLES(8)) dut_u (.clk(clk), .rst_b(rst_b), .cfg(cfg),
    .contact_fn({40'h0, 8'h22, 8'h23, 8'h1f, 8'h1e, 8'h13}), .contact_pin(pins), .src(src),
    .second_adj(unity), .third_adj(unity), .pulse_adj(unity), .pulse_scale(16'h0100),
    .max_freq(16'h0800), .run(run), .reset_cmd(rcmd), .host_wr(hwr), .host_rd(hrd),
    .host_addr(ha), .host_wdata(hwd), .host_rdata(hrdata), .host_ack(hack),
    .freq_out(fout), .freq_ref_out(fref), .pid_active(pact), .char_switch(chs),
    .pid_out_mon(pmon));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task host(input logic wr, input logic [3:0] a, input logic [15:0] d);
    @(negedge clk);
    hwr = wr;
    hrd = !wr;
    ha = a;
    hwd = d;
    @(negedge clk);
    hwr = 1'b0;
    hrd = 1'b0;
    chk({15'h0, hack}, 16'h0001);
  endtask : host

  // New target, then watch the output for one value
  task watch(input logic [15:0] t1, input logic [15:0] peak, output logic seen_peak);
    host(1'b1, 4'h6, t1);
    seen_peak = 1'b0;
    repeat (30)
    begin
      @(negedge clk);
      if (fout == peak)
        seen_peak = 1'b1;
    end
  endtask : watch

  task report_and_stop;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      report_and_stop;
    end
  end

  initial
  begin
    repeat (20) @(negedge clk);
    chk(fout, 16'h0000);
    rst_b = 1'b1;
    host(1'b0, 4'h6, 16'h0);
    chk(hrdata, 16'h0000);
    host(1'b0, 4'hf, 16'h0);
    chk(hrdata, 16'h0000);
    host(1'b1, 4'h6, 16'h1234);
    host(1'b0, 4'h6, 16'h0);
    chk(hrdata, 16'h1234);
    host(1'b1, 4'h3, 16'hbeef);
    host(1'b0, 4'h3, 16'h0);
    chk(hrdata, 16'h0000);
    $display("test done: host registers");
    host(1'b1, 4'h6, 16'h0600);
    foreach (rows[i])
    begin
      cfg.method = rows[i].m;
      cfg.prop_gain = rows[i].g;
      cfg.second_fn = rows[i].s2;
      cfg.third_fn = rows[i].s3;
      cfg.pulse_fn = rows[i].pf;
      host(1'b1, 4'hf, {14'h0, rows[i].fl, 1'b0});
      repeat (60) @(negedge clk);
      chk(fout, rows[i].e);
      chk({15'h0, pact}, {15'h0, rows[i].m != 3'h0});
    end
    $display("test done: source and method rows");
    cfg.method = 3'h1;
    cfg.pulse_fn = 2'h0;
    repeat (10) @(negedge clk);
    chk(fref, 16'h0080);
    pins = 10'h001;
    repeat (10) @(negedge clk);
    chk(fout, 16'h0500);
    chk({15'h0, pact}, 16'h0000);
    pins = 10'h018;
    repeat (60) @(negedge clk);
    chk(fout, 16'h0600);
    chk({15'h0, chs}, 16'h0001);
    $display("test done: contact functions");
    pins = 10'h000;
    cfg.prop_gain = 16'h0000;
    cfg.integral_time = 16'h0001;
    host(1'b1, 4'h6, 16'h0010);
    repeat (20) @(negedge clk);
    chk({15'h0, fout != 16'h0}, 16'h0001);
    pins = 10'h004;
    repeat (20) @(negedge clk);
    v = fout;
    repeat (40) @(negedge clk);
    chk(fout, v);
    pins = 10'h006;
    repeat (20) @(negedge clk);
    chk(fout, 16'h0000);
    $display("test done: integrator");
    pins = 10'h000;
    repeat (30) @(negedge clk);
    chk({15'h0, fout != 16'h0}, 16'h0001);
    rcmd = 1'b1;
    repeat (20) @(negedge clk);
    chk(fout, 16'h0000);
    rcmd = 1'b0;
    repeat (30) @(negedge clk);
    chk({15'h0, fout != 16'h0}, 16'h0001);
    run = 1'b0;
    cfg.integral_time = 16'h0000;
    repeat (20) @(negedge clk);
    chk(fout, 16'h0000);
    $display("test done: integrator clear");
    run = 1'b1;
    cfg.prop_gain = 16'h0100;
    cfg.method = 3'h2;
    cfg.derivative_time = 16'h0100;
    host(1'b1, 4'h6, 16'h0100);
    repeat (30) @(negedge clk);
    watch(16'h0200, 16'h0300, hit);
    chk({15'h0, hit}, 16'h0000);
    chk(fout, 16'h0200);
    cfg.method = 3'h1;
    repeat (30) @(negedge clk);
    watch(16'h0300, 16'h0400, hit);
    chk({15'h0, hit}, 16'h0001);
    chk(fout, 16'h0300);
    cfg.derivative_time = 16'h0000;
    repeat (30) @(negedge clk);
    watch(16'h0100, 16'hff00, hit);
    chk({15'h0, hit}, 16'h0000);
    chk(fout, 16'h0100);
    chk(pmon, 16'h0100);
    $display("test done: derivative");
    cfg.filter_time = 16'h0001;
    watch(16'h0300, 16'h0200, hit);
    chk({15'h0, hit}, 16'h0001);
    chk({15'h0, fout < 16'h0300}, 16'h0001);
    cfg.filter_time = 16'h0000;
    cfg.ramp_time = 16'h0001;
    repeat (30) @(negedge clk);
    host(1'b1, 4'h6, 16'h0100);
    repeat (30) @(negedge clk);
    chk({15'h0, fout > 16'h02f0}, 16'h0001);
    pins = 10'h010;
    repeat (20) @(negedge clk);
    chk(fout, 16'h0100);
    pins = 10'h000;
    $display("test done: filter and ramp");
    report_and_stop;
  end
endmodule : dpcs_top_tb_top
